// *** inc/ocd_pkg.sv ***
`default_nettype none
package ocd_pkg;

	// ---------------------------------------------------------------
	// bus geometry
	// ---------------------------------------------------------------
	localparam int unsigned OCD_AW    = 8;
	localparam int unsigned OCD_DW    = 32;
	localparam int unsigned OCD_DIV_W = 8;

	// ---------------------------------------------------------------
	// register indices and byte addresses (index times four)
	// ---------------------------------------------------------------
	localparam logic [5:0] OCD_IDX_DIV01 = 6'h21;
	localparam logic [5:0] OCD_IDX_CTL2  = 6'h22;
	localparam logic [5:0] OCD_IDX_CTL3  = 6'h23;
	localparam logic [7:0] OCD_ADDR_DIV01 = {OCD_IDX_DIV01, 2'h0};
	localparam logic [7:0] OCD_ADDR_CTL2  = {OCD_IDX_CTL2, 2'h0};
	localparam logic [7:0] OCD_ADDR_CTL3  = {OCD_IDX_CTL3, 2'h0};

	// ---------------------------------------------------------------
	// field positions of the control registers
	// ---------------------------------------------------------------
	localparam int unsigned OCD_SRC_B  = 7;
	localparam int unsigned OCD_FMT_HI = 6;
	localparam int unsigned OCD_FMT_LO = 5;
	localparam int unsigned OCD_MA_HI  = 4;
	localparam int unsigned OCD_MA_LO  = 3;
	localparam int unsigned OCD_MB_HI  = 2;
	localparam int unsigned OCD_MB_LO  = 1;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] OCD_DIV_RST = 8'h01;
	localparam logic       OCD_SRC_RST = 1'h1;
	localparam logic [1:0] OCD_FMT_RST = 2'h1;
	localparam logic [1:0] OCD_MA_RST  = 2'h2;
	localparam logic [1:0] OCD_MB_RST  = 2'h0;

	// ---------------------------------------------------------------
	// decoded driver values
	// ---------------------------------------------------------------
	localparam logic [4:0] OCD_TAIL_0MA  = 5'h00;
	localparam logic [4:0] OCD_TAIL_4MA  = 5'h04;
	localparam logic [4:0] OCD_TAIL_6MA  = 5'h06;
	localparam logic [4:0] OCD_TAIL_8MA  = 5'h08;
	localparam logic [4:0] OCD_TAIL_16MA = 5'h10;
	localparam logic [7:0] OCD_RL_OPEN   = 8'h00;
	localparam logic [7:0] OCD_RL_50     = 8'h32;
	localparam logic [7:0] OCD_RL_100    = 8'h64;
	localparam logic [7:0] OCD_RL_200    = 8'hC8;

	typedef enum logic [1:0] {
		OCD_FMT_OFF  = 2'b00,
		OCD_FMT_AC   = 2'b01,
		OCD_FMT_HCSL = 2'b10,
		OCD_FMT_CMOS = 2'b11
	} ocd_fmt_t;

	typedef enum logic [1:0] {
		OCD_SE_PD_Z   = 2'b00,
		OCD_SE_PD_LOW = 2'b01,
		OCD_SE_UP_INV = 2'b10,
		OCD_SE_UP_POS = 2'b11
	} ocd_se_t;

	typedef enum logic [0:0] {
		OCD_APB_IDLE = 1'b0,
		OCD_APB_ACK  = 1'b1
	} ocd_apb_st_t;

	typedef struct packed {
		logic       out_en;
		logic [4:0] tail_ma;
		logic [7:0] rload;
		logic       p_oe;
		logic       p_pwr;
		logic       p_inv;
		logic       n_oe;
		logic       n_pwr;
		logic       n_inv;
	} ocd_drv_t;

endpackage
`default_nettype wire

// *** inc/ocd_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ocd_div_if #(parameter int unsigned DW = 8);
	logic [DW-1:0] ratio_m1;
	logic          tick;
	modport cfg (output ratio_m1, input tick);
	modport div (input ratio_m1, output tick);
endinterface
`default_nettype wire

// *** rtl/ocd_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocd_divider
	import ocd_pkg::*;
#(
	parameter int unsigned DW = OCD_DIV_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// ratio in, tick out
	ocd_div_if.div   div_if
);

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	logic [DW-1:0] cnt_q;
	logic          tick_q;

	// compare with >= so a ratio lowered mid-period never overruns
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q >= div_if.ratio_m1) begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= DW'(cnt_q + 1'b1);
			tick_q <= 1'b0;
		end
	end

	assign div_if.tick = tick_q;

	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	logic [DW:0]   gap_q;
	logic [DW-1:0] prev_q;
	logic          chg_q;
	logic          seen_q;

	// cycles since the last tick, and whether the ratio moved meanwhile
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_q  <= '0;
			prev_q <= '0;
			chg_q  <= 1'b1;
			seen_q <= 1'b0;
		end else begin
			prev_q <= div_if.ratio_m1;
			gap_q  <= tick_q ? '0 : (DW+1)'(gap_q + 1'b1);
			seen_q <= seen_q | tick_q;
			if (tick_q)
				chg_q <= (div_if.ratio_m1 != prev_q);
			else if (div_if.ratio_m1 != prev_q)
				chg_q <= 1'b1;
		end
	end

	property p_tick_period;
		@(posedge core_clk_i) disable iff (!rstn_i)
		tick_q && seen_q && !chg_q && (div_if.ratio_m1 == prev_q)
			|-> gap_q == {1'b0, div_if.ratio_m1};
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("divider period differs from ratio plus one");

	property p_ratio_one;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(div_if.ratio_m1 == '0) [*2] |=> tick_q;
	endproperty
	a_ratio_one: assert property (p_ratio_one)
		else $error("ratio one does not tick every cycle");

endmodule
`default_nettype wire

// *** rtl/ocd_top.sv ***
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - one divider drives channels zero and one
// - eight-bit divider field, reset value 0x01
// - division ratio is field value plus one
// - channel 2/3 source: first or second synthesizer
// - channel two control register bit layout
// - channel three layout, bits 7, 0 reserved
// - format: off, AC family, HCSL, CMOS
// - CMOS positive output power and polarity
// - differential tail current from mode a
// - mode b: HCSL load or CMOS negative
module ocd_top
	import ocd_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rstn_i,
	// apb slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [OCD_AW-1:0] paddr_i,
	input  wire logic [OCD_DW-1:0] pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic      [OCD_DW-1:0] prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// synthesizer clock enables
	input  wire logic              first_synth_tick_i,
	input  wire logic              second_synth_tick_i,
	// channel 0/1 divided ticks
	output logic                   ch0_tick_o,
	output logic                   ch1_tick_o,
	// channel 2/3 source
	output logic                   ch23_src_sel_o,
	output logic                   ch23_src_tick_o,
	// channel 2 driver
	output logic [1:0]             ch2_fmt_o,
	output logic                   ch2_out_en_o,
	output logic [4:0]             ch2_tail_ma_o,
	output logic [7:0]             ch2_rload_ohm_o,
	output logic                   ch2_p_oe_o,
	output logic                   ch2_p_pwr_o,
	output logic                   ch2_p_inv_o,
	output logic                   ch2_n_oe_o,
	output logic                   ch2_n_pwr_o,
	output logic                   ch2_n_inv_o,
	// channel 3 driver
	output logic [1:0]             ch3_fmt_o,
	output logic                   ch3_out_en_o,
	output logic [4:0]             ch3_tail_ma_o,
	output logic [7:0]             ch3_rload_ohm_o,
	output logic                   ch3_p_oe_o,
	output logic                   ch3_p_pwr_o,
	output logic                   ch3_p_inv_o,
	output logic                   ch3_n_oe_o,
	output logic                   ch3_n_pwr_o,
	output logic                   ch3_n_inv_o
);

	// ---------------------------------------------------------------
	// driver decode
	// ---------------------------------------------------------------
	function automatic ocd_drv_t ocd_decode(
		input logic [1:0] fmt,
		input logic [1:0] ma,
		input logic [1:0] mb
	);
		ocd_drv_t r;
		r = '0;
		case (fmt)
			OCD_FMT_AC, OCD_FMT_HCSL: begin
				r.out_en = 1'b1;
				r.p_oe   = 1'b1;
				r.p_pwr  = 1'b1;
				r.n_oe   = 1'b1;
				r.n_pwr  = 1'b1;
				// code 3 depends on the family in use
				case (ma)
					2'h0:    r.tail_ma = OCD_TAIL_4MA;
					2'h1:    r.tail_ma = OCD_TAIL_6MA;
					2'h2:    r.tail_ma = OCD_TAIL_8MA;
					default: r.tail_ma = (fmt == OCD_FMT_HCSL) ?
						OCD_TAIL_16MA : OCD_TAIL_8MA;
				endcase
				// load only exists in HCSL; AC family leaves it open
				if (fmt == OCD_FMT_HCSL) begin
					case (mb)
						2'h0:    r.rload = OCD_RL_OPEN;
						2'h1:    r.rload = OCD_RL_50;
						2'h2:    r.rload = OCD_RL_100;
						default: r.rload = OCD_RL_200;
					endcase
				end
			end
			OCD_FMT_CMOS: begin
				r.out_en = 1'b1;
				r.p_oe   = (ma != OCD_SE_PD_Z);
				r.p_pwr  = ma[1];
				r.p_inv  = (ma == OCD_SE_UP_INV);
				r.n_oe   = (mb != OCD_SE_PD_Z);
				r.n_pwr  = mb[1];
				r.n_inv  = (mb == OCD_SE_UP_INV);
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	localparam ocd_drv_t OCD_DRV_RST = ocd_decode(OCD_FMT_RST, OCD_MA_RST, OCD_MB_RST);
	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	ocd_apb_st_t      st_q;
	logic             hit_div;
	logic             hit_ctl2;
	logic             hit_ctl3;
	logic             hit_any;
	logic             access;
	logic             commit_wr;
	logic [OCD_DW-1:0] rd_d;

	// address decode; anything else answers with an error
	always_comb begin
		hit_div  = 1'b0;
		hit_ctl2 = 1'b0;
		hit_ctl3 = 1'b0;
		if (paddr_i == OCD_ADDR_DIV01) begin
			hit_div = 1'b1;
		end else if (paddr_i == OCD_ADDR_CTL2) begin
			hit_ctl2 = 1'b1;
		end else if (paddr_i == OCD_ADDR_CTL3) begin
			hit_ctl3 = 1'b1;
		end
	end

	assign hit_any   = hit_div | hit_ctl2 | hit_ctl3;
	assign access    = psel_i & penable_i;
	// writes land on the edge that samples pready high, lane 0 only
	assign commit_wr = access & (st_q == OCD_APB_ACK) & pwrite_i & pstrb_i[0] & hit_any;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [OCD_DIV_W-1:0] div_q;
	logic                 src_q;
	logic [1:0]           fmt2_q;
	logic [1:0]           ma2_q;
	logic [1:0]           mb2_q;
	logic [1:0]           fmt3_q;
	logic [1:0]           ma3_q;
	logic [1:0]           mb3_q;

	// shared divider field, whole byte
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q <= OCD_DIV_RST;
		end else if (commit_wr && hit_div) begin
			div_q <= pwdata_i[OCD_DIV_W-1:0];
		end
	end

	// channel 2 control; bit 0 has no storage
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			src_q  <= OCD_SRC_RST;
			fmt2_q <= OCD_FMT_RST;
			ma2_q  <= OCD_MA_RST;
			mb2_q  <= OCD_MB_RST;
		end else if (commit_wr && hit_ctl2) begin
			src_q  <= pwdata_i[OCD_SRC_B];
			fmt2_q <= pwdata_i[OCD_FMT_HI:OCD_FMT_LO];
			ma2_q  <= pwdata_i[OCD_MA_HI:OCD_MA_LO];
			mb2_q  <= pwdata_i[OCD_MB_HI:OCD_MB_LO];
		end
	end

	// channel 3 control; bits 7 and 0 have no storage
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fmt3_q <= OCD_FMT_RST;
			ma3_q  <= OCD_MA_RST;
			mb3_q  <= OCD_MB_RST;
		end else if (commit_wr && hit_ctl3) begin
			fmt3_q <= pwdata_i[OCD_FMT_HI:OCD_FMT_LO];
			ma3_q  <= pwdata_i[OCD_MA_HI:OCD_MA_LO];
			mb3_q  <= pwdata_i[OCD_MB_HI:OCD_MB_LO];
		end
	end

	// read mux; reserved and upper bits stay zero
	always_comb begin
		rd_d = '0;
		if (hit_div) begin
			rd_d[OCD_DIV_W-1:0] = div_q;
		end else if (hit_ctl2) begin
			rd_d[OCD_SRC_B]             = src_q;
			rd_d[OCD_FMT_HI:OCD_FMT_LO] = fmt2_q;
			rd_d[OCD_MA_HI:OCD_MA_LO]   = ma2_q;
			rd_d[OCD_MB_HI:OCD_MB_LO]   = mb2_q;
		end else if (hit_ctl3) begin
			rd_d[OCD_FMT_HI:OCD_FMT_LO] = fmt3_q;
			rd_d[OCD_MA_HI:OCD_MA_LO]   = ma3_q;
			rd_d[OCD_MB_HI:OCD_MB_LO]   = mb3_q;
		end
	end

	// ---------------------------------------------------------------
	// apb response
	// ---------------------------------------------------------------
	// one wait state keeps pready, prdata and pslverr registered
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q      <= OCD_APB_IDLE;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			case (st_q)
				OCD_APB_IDLE: begin
					if (access) begin
						st_q      <= OCD_APB_ACK;
						pready_o  <= 1'b1;
						pslverr_o <= ~hit_any;
						prdata_o  <= pwrite_i ? '0 : rd_d;
					end
				end
				default: begin
					st_q      <= OCD_APB_IDLE;
					pready_o  <= 1'b0;
					pslverr_o <= 1'b0;
					prdata_o  <= '0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// shared channel 0/1 divider
	// ---------------------------------------------------------------
	ocd_div_if #(.DW(OCD_DIV_W)) div_bus ();
	assign div_bus.ratio_m1 = div_q;
	ocd_divider #(.DW(OCD_DIV_W)) u_div (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.div_if     (div_bus)
	);

	// both channels retime the same tick, so they never drift apart
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ch0_tick_o <= 1'b0;
			ch1_tick_o <= 1'b0;
		end else begin
			ch0_tick_o <= div_bus.tick;
			ch1_tick_o <= div_bus.tick;
		end
	end

	// ---------------------------------------------------------------
	// channel 2/3 source and drivers
	// ---------------------------------------------------------------
	ocd_drv_t drv2_q;
	ocd_drv_t drv3_q;

	// selector switches on the register edge; a runt tick may occur
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ch23_src_sel_o  <= OCD_SRC_RST;
			ch23_src_tick_o <= 1'b0;
		end else begin
			ch23_src_sel_o  <= src_q;
			ch23_src_tick_o <= src_q ? second_synth_tick_i : first_synth_tick_i;
		end
	end

	// decoded driver controls for both channels
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drv2_q <= OCD_DRV_RST;
			drv3_q <= OCD_DRV_RST;
		end else begin
			drv2_q <= ocd_decode(fmt2_q, ma2_q, mb2_q);
			drv3_q <= ocd_decode(fmt3_q, ma3_q, mb3_q);
		end
	end

	// field order of the driver struct matches each port group
	assign ch2_fmt_o = fmt2_q;
	assign ch3_fmt_o = fmt3_q;
	assign {ch2_out_en_o, ch2_tail_ma_o, ch2_rload_ohm_o,
		ch2_p_oe_o, ch2_p_pwr_o, ch2_p_inv_o, ch2_n_oe_o, ch2_n_pwr_o, ch2_n_inv_o} = drv2_q;
	assign {ch3_out_en_o, ch3_tail_ma_o, ch3_rload_ohm_o,
		ch3_p_oe_o, ch3_p_pwr_o, ch3_p_inv_o, ch3_n_oe_o, ch3_n_pwr_o, ch3_n_inv_o} = drv3_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_one_wait;
		@(posedge core_clk_i) disable iff (!rstn_i)
		access && !pready_o |=> pready_o ##1 !pready_o;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("apb answer is not exactly one wait state");
	property p_shared_div;
		@(posedge core_clk_i) disable iff (!rstn_i)
		ch0_tick_o == ch1_tick_o;
	endproperty
	a_shared_div: assert property (p_shared_div)
		else $error("channel 0 and 1 ticks differ");
	property p_div_write;
		@(posedge core_clk_i) disable iff (!rstn_i)
		commit_wr && hit_div |=> div_q == $past(pwdata_i[OCD_DIV_W-1:0]);
	endproperty
	a_div_write: assert property (p_div_write)
		else $error("divider write not stored");
	property p_ctl2_map;
		@(posedge core_clk_i) disable iff (!rstn_i)
		commit_wr && hit_ctl2 |=> src_q == $past(pwdata_i[OCD_SRC_B])
			&& ma2_q == $past(pwdata_i[OCD_MA_HI:OCD_MA_LO]);
	endproperty
	a_ctl2_map: assert property (p_ctl2_map)
		else $error("channel 2 fields misplaced");
	property p_ctl3_rsvd;
		@(posedge core_clk_i) disable iff (!rstn_i)
		access && !pwrite_i && hit_ctl3 && !pready_o
			|=> prdata_o[OCD_SRC_B] == 1'b0 && prdata_o[0] == 1'b0
			&& prdata_o[OCD_DW-1:OCD_DIV_W] == '0;
	endproperty
	a_ctl3_rsvd: assert property (p_ctl3_rsvd)
		else $error("channel 3 reserved bits read nonzero");
	property p_src_route;
		@(posedge core_clk_i) disable iff (!rstn_i)
		!src_q |=> ch23_src_tick_o == $past(first_synth_tick_i);
	endproperty
	a_src_route: assert property (p_src_route)
		else $error("cleared selector does not route first synthesizer");
	property p_fmt_off;
		@(posedge core_clk_i) disable iff (!rstn_i)
		fmt3_q == OCD_FMT_OFF |=> !ch3_out_en_o && !ch3_p_oe_o && !ch3_n_oe_o;
	endproperty
	a_fmt_off: assert property (p_fmt_off)
		else $error("disabled channel 3 still drives");
	property p_cmos_inv;
		@(posedge core_clk_i) disable iff (!rstn_i)
		fmt2_q == OCD_FMT_CMOS && ma2_q == OCD_SE_UP_INV
			|=> ch2_p_inv_o && ch2_p_pwr_o && ch2_p_oe_o;
	endproperty
	a_cmos_inv: assert property (p_cmos_inv)
		else $error("cmos inverted positive output wrong");
	property p_hcsl_tail;
		@(posedge core_clk_i) disable iff (!rstn_i)
		fmt2_q == OCD_FMT_HCSL && ma2_q == 2'h3 |=> ch2_tail_ma_o == OCD_TAIL_16MA;
	endproperty
	a_hcsl_tail: assert property (p_hcsl_tail)
		else $error("hcsl top tail current not 16 mA");
	property p_hcsl_load;
		@(posedge core_clk_i) disable iff (!rstn_i)
		fmt3_q == OCD_FMT_HCSL && mb3_q == 2'h1 |=> ch3_rload_ohm_o == OCD_RL_50;
	endproperty
	a_hcsl_load: assert property (p_hcsl_load)
		else $error("hcsl load code 1 not 50 ohm");

endmodule
`default_nettype wire

// *** bench/ocd_sink_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ocd_sink_model (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	// received channel 0/1 ticks
	input  wire logic       ch0_tick_i,
	input  wire logic       ch1_tick_i,
	// measured spacing, pairing fault
	output logic      [9:0] period_o,
	output logic            skew_o
);
	logic [9:0] gap_q;

	// spacing between ticks, as a downstream flop would see it
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_q    <= 10'h000;
			period_o <= 10'h000;
		end else begin
			gap_q <= ch0_tick_i ? 10'h000 : gap_q + 10'h001;
			if (ch0_tick_i) begin
				period_o <= gap_q + 10'h001;
			end
		end
	end

	// one shared divider: any difference between channels is sticky
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			skew_o <= 1'b0;
		end else begin
			skew_o <= skew_o | (ch0_tick_i != ch1_tick_i);
		end
	end
endmodule
`default_nettype wire

// *** bench/ocd_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin n_fail++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, x); end end
module ocd_top_test
	import ocd_pkg::*;
;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic        core_clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
	logic        pwrite_i = 1'b0, first_synth_tick_i = 1'b0, second_synth_tick_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [3:0]  pstrb_i = 4'hF;
	logic [1:0]  tcnt = 2'h0, ch2_fmt_o, ch3_fmt_o;
	logic        pready_o, pslverr_o, ch0_tick_o, ch1_tick_o, ch23_src_sel_o, ch23_src_tick_o;
	logic        ch2_out_en_o, ch2_p_oe_o, ch2_p_pwr_o, ch2_p_inv_o, ch2_n_oe_o, ch2_n_pwr_o;
	logic        ch3_out_en_o, ch3_p_oe_o, ch3_p_pwr_o, ch3_p_inv_o, ch3_n_oe_o, ch3_n_pwr_o;
	logic        ch2_n_inv_o, ch3_n_inv_o, er, skew;
	logic [4:0]  ch2_tail_ma_o, ch3_tail_ma_o;
	logic [7:0]  ch2_rload_ohm_o, ch3_rload_ohm_o;
	logic [9:0]  period;
	int          n_fail = 0, samples_checked = 0;
	localparam logic [19:0] RST_E = {1'h1, 5'h08, 8'h00, 6'h36};
	typedef struct {logic [7:0] v; logic [19:0] e;} ocd_row_t;
	ocd_row_t rows[12] = '{
		'{8'h91, {1'h0, 5'h00, 8'h00, 6'h00}}, '{8'h27, {1'h1, 5'h04, 8'h00, 6'h36}},
		'{8'h28, {1'h1, 5'h06, 8'h00, 6'h36}}, '{8'h38, {1'h1, 5'h08, 8'h00, 6'h36}},
		'{8'h40, {1'h1, 5'h04, 8'h00, 6'h36}}, '{8'h4A, {1'h1, 5'h06, 8'h32, 6'h36}},
		'{8'h54, {1'h1, 5'h08, 8'h64, 6'h36}}, '{8'h5E, {1'h1, 5'h10, 8'hC8, 6'h36}},
		'{8'h62, {1'h1, 5'h00, 8'h00, 6'h04}}, '{8'h76, {1'h1, 5'h00, 8'h00, 6'h3E}},
		'{8'h7C, {1'h1, 5'h00, 8'h00, 6'h37}}, '{8'h68, {1'h1, 5'h00, 8'h00, 6'h20}}};
	wire logic [19:0] ch2_vec = {ch2_out_en_o, ch2_tail_ma_o, ch2_rload_ohm_o, ch2_p_oe_o,
		ch2_p_pwr_o, ch2_p_inv_o, ch2_n_oe_o, ch2_n_pwr_o, ch2_n_inv_o};
	wire logic [19:0] ch3_vec = {ch3_out_en_o, ch3_tail_ma_o, ch3_rload_ohm_o, ch3_p_oe_o,
		ch3_p_pwr_o, ch3_p_inv_o, ch3_n_oe_o, ch3_n_pwr_o, ch3_n_inv_o};

	// ---------------------------------------------------------------
	// clock, synthesizer ticks, design and far side
	// ---------------------------------------------------------------
	// 40 MHz core clock
	always #12.5 core_clk_i = ~core_clk_i;
	// two unlike tick patterns so a wrong source shows
	always @(posedge core_clk_i) begin
		tcnt <= tcnt + 2'h1;
		first_synth_tick_i <= tcnt[0];
		second_synth_tick_i <= tcnt[1];
	end
	ocd_top u_ocd_top (.core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .first_synth_tick_i,
		.second_synth_tick_i, .ch0_tick_o, .ch1_tick_o, .ch23_src_sel_o, .ch23_src_tick_o,
		.ch2_fmt_o, .ch2_out_en_o, .ch2_tail_ma_o, .ch2_rload_ohm_o, .ch2_p_oe_o, .ch2_p_pwr_o,
		.ch2_p_inv_o, .ch2_n_oe_o, .ch2_n_pwr_o, .ch2_n_inv_o, .ch3_fmt_o, .ch3_out_en_o,
		.ch3_tail_ma_o, .ch3_rload_ohm_o, .ch3_p_oe_o, .ch3_p_pwr_o, .ch3_p_inv_o, .ch3_n_oe_o,
		.ch3_n_pwr_o, .ch3_n_inv_o);
	ocd_sink_model u_ocd_sink_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.ch0_tick_i(ch0_tick_o), .ch1_tick_i(ch1_tick_o), .period_o(period), .skew_o(skew));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	// verdict and stop, shared by the main flow and the bus timeout
	task automatic end_of_test();
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one apb transfer; answer taken and request dropped at the edge that sees pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk_i);
			if (pready_o === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			end_of_test();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// reset values, also seen again after a mid-run reset
	task automatic chk_rst();
		apb(1'b0, OCD_ADDR_DIV01, 32'h0);
		`CHK(rd, 32'h01)
		apb(1'b0, OCD_ADDR_CTL2, 32'h0);
		`CHK(rd, 32'hB0)
		apb(1'b0, OCD_ADDR_CTL3, 32'h0);
		`CHK(rd, 32'h30)
		`CHK(period, 10'h002)
		`CHK(ch2_vec, RST_E)
		`CHK(ch23_src_sel_o, 1'b1)
		$display("test reset values done");
	endtask
	// source tick must follow the chosen synthesizer one clock late
	task automatic chk_src(input logic sel);
		logic p;
		apb(1'b1, OCD_ADDR_CTL2, {24'h0, sel, 7'h2C});
		repeat (2) @(negedge core_clk_i);
		p = sel ? second_synth_tick_i : first_synth_tick_i;
		repeat (4) begin
			@(negedge core_clk_i);
			`CHK(ch23_src_tick_o, p)
			p = sel ? second_synth_tick_i : first_synth_tick_i;
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		chk_rst();
		// decode table; upper and reserved bits written high to prove they drop
		foreach (rows[i]) begin
			apb(1'b1, OCD_ADDR_CTL2, {24'hFFFFFF, rows[i].v});
			apb(1'b1, OCD_ADDR_CTL3, {24'hFFFFFF, rows[i].v});
			apb(1'b0, OCD_ADDR_CTL2, 32'h0);
			`CHK(rd, {24'h0, rows[i].v & 8'hFE})
			apb(1'b0, OCD_ADDR_CTL3, 32'h0);
			`CHK(rd, {24'h0, rows[i].v & 8'h7E})
			`CHK(ch23_src_sel_o, rows[i].v[7])
			`CHK({ch2_fmt_o, ch3_fmt_o}, {2{rows[i].v[6:5]}})
			`CHK(ch2_vec, rows[i].e)
			`CHK(ch3_vec, rows[i].e)
			`CHK({ch2_rload_ohm_o, ch3_rload_ohm_o}, {2{rows[i].e[13:6]}})
		end
		$display("test decode table done");
		chk_src(1'b0);
		chk_src(1'b1);
		$display("test source select done");
		// divider extremes and a middle value; wait three full periods
		for (int k = 0; k < 3; k++) begin
			logic [7:0] dv;
			dv = (k == 0) ? 8'h00 : (k == 1) ? 8'h03 : 8'hFF;
			apb(1'b1, OCD_ADDR_DIV01, {24'h0, dv});
			repeat (3 * (int'(dv) + 1) + 4) @(negedge core_clk_i);
			`CHK(period, {2'h0, dv} + 10'h001)
			apb(1'b0, OCD_ADDR_DIV01, 32'h0);
			`CHK(rd, {24'h0, dv})
		end
		`CHK(skew, 1'b0)
		$display("test divider done");
		// unmapped place refused, masked byte lane ignored
		apb(1'b1, 8'h90, 32'h0);
		`CHK(er, 1'b1)
		apb(1'b0, 8'h90, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		pstrb_i <= 4'hE;
		apb(1'b1, OCD_ADDR_CTL2, 32'h0);
		pstrb_i <= 4'hF;
		apb(1'b0, OCD_ADDR_CTL2, 32'h0);
		`CHK({er, rd}, {1'b0, 32'hAC})
		apb(1'b0, OCD_ADDR_DIV01, 32'h0);
		`CHK(rd, 32'hFF)
		$display("test refusals done");
		// reset in mid-run must restore every default
		rstn_i <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		`CHK({ch2_vec, ch3_vec, pready_o}, {RST_E, RST_E, 1'b0})
		@(posedge core_clk_i);
		rstn_i <= 1'b1;
		chk_rst();
		end_of_test();
	end
endmodule
`default_nettype wire
